// file: rtl/fifo_device.sv
// Standard-mode FIFO with status flags and a serial offset chain.
// Overview of operation
// - Store word when write gate and select low.
// - Empty indicator rises after first write.
// - Almost-empty rises at n plus one words.
// - Almost-full falls at depth minus m words.
// - x20 dual halves the almost-full depth.
// - Full indicator low, further writes refused.
// - Full after exactly depth writes.
// - x20 dual full after half depth writes.
// - First read from full releases full indicator.
// - Almost-full rises below depth minus m.
// - Almost-empty falls at n words.
// - Last word read: empty low, reads refused.
// - Empty ignores read gate; select drives bus.
// - Empty and full pass two register stages.
// - Works for single and double rate ports.
// - Quad chain order E3 F3 E2 F2 E1 F1 E0 F0.
// - Dual chain holds FIFOs two and zero.
// - First bit of each field is LSB.
// - Fall-through low at reset selects standard.
// - Every read needs gate and select.
// - Unprogrammed offsets take strap default value.
// - Load enable low shifts one bit per clock.
//
// The register addresses and register access over APB are this design's own decisions.
module fifo_device (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins toward the writer and reader
	fifo_link.device_end lk,
	// Local status
	output logic standard_mode,
	output logic [15:0] fill_level
);
	// ==================================================
	// Configuration caught in the first cycle after reset release.
	logic cfg_done_r;
	logic std_mode_r;
	logic quad_r;
	logic x20_r;
	logic quad_now;
	logic x20_now;

	// Straps are sampled by a clocked process, never by the reset itself.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_done_r <= 1'b0;
			std_mode_r <= 1'b1;
			quad_r <= 1'b1;
			x20_r <= 1'b0;
		end else if (!cfg_done_r) begin
			cfg_done_r <= 1'b1;
			std_mode_r <= !lk.fall_through_select;
			quad_r <= lk.quad_mode;
			x20_r <= lk.port_width_setting;
		end
	end

	assign quad_now = cfg_done_r ? quad_r : lk.quad_mode;
	assign x20_now = cfg_done_r ? x20_r : lk.port_width_setting;
	assign standard_mode = std_mode_r;

	// ==================================================
	// Serial clock edge, generated by the host from the same clock.
	logic sclk_d_r;
	logic sedge;
	logic [14:0] empty_off;
	logic [14:0] full_off;

	// Previous serial clock level for rising edge detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= lk.serial_clk;
		end
	end

	assign sedge = lk.serial_clk && !sclk_d_r;

	// Offset chain; loading and dumping at once is not allowed by the host.
	offset_chain u_chain (
		.pclk(pclk),
		.presetn(presetn),
		.load_defaults(!cfg_done_r),
		.default_select(lk.default_offset_select),
		.quad(quad_now),
		.x20(x20_now),
		.shift_step(sedge && !lk.serial_load_enable_n),
		.shift_in(lk.serial_in),
		.dump_active_n(lk.serial_dump_enable_n),
		.dump_step(sedge && !lk.serial_dump_enable_n),
		.dump_out(lk.serial_out),
		.empty_offset(empty_off),
		.full_offset(full_off)
	);

	// ==================================================
	// Storage and pointers.
	logic [9:0] mem [fifo_pkg::DEPTH_X10];
	logic [14:0] wptr_r;
	logic [14:0] rptr_r;
	logic [15:0] count_r;
	logic [15:0] depth_now;
	logic wr_take;
	logic rd_take;

	// Pointer advance that wraps at the active depth.
	function automatic logic [14:0] next_ptr(input logic [14:0] p, input logic [15:0] depth);
		next_ptr = (16'({1'b0, p}) == depth - 16'h0001) ? 15'h0000 : p + 15'h0001;
	endfunction

	// Word depth per configuration; x20 dual uses half.
	assign depth_now = (!quad_r && x20_r) ? fifo_pkg::DEPTH_X20 : fifo_pkg::DEPTH_X10;

	// Accept terms: full refuses writes, empty ignores the read gate.
	assign wr_take = cfg_done_r && std_mode_r && !lk.write_gate_n && !lk.write_select_n
		&& (count_r != depth_now);
	assign rd_take = cfg_done_r && std_mode_r && !lk.read_gate_n && !lk.read_select_n
		&& (count_r != 16'h0000);

	// Write side: data is stored at the write pointer.
	always_ff @(posedge pclk) begin
		if (wr_take) begin
			mem[wptr_r] <= lk.wdata;
		end
	end

	// Write pointer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_r <= '0;
		end else if (wr_take) begin
			wptr_r <= next_ptr(wptr_r, depth_now);
		end
	end

	// Read pointer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rptr_r <= '0;
		end else if (rd_take) begin
			rptr_r <= next_ptr(rptr_r, depth_now);
		end
	end

	// Stored word count; a write and a read together leave it unchanged.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= '0;
		end else if (wr_take && !rd_take) begin
			count_r <= count_r + 16'h0001;
		end else if (rd_take && !wr_take) begin
			count_r <= count_r - 16'h0001;
		end
	end

	assign fill_level = count_r;

	// ==================================================
	// Read data and bus drive.
	logic [9:0] rdata_r;
	logic rdata_oe_r;

	// Output word is updated only by an accepted read.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= '0;
		end else if (rd_take) begin
			rdata_r <= mem[rptr_r];
		end
	end

	// Read select alone decides the bus drive, empty or not.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_oe_r <= 1'b0;
		end else begin
			rdata_oe_r <= !lk.read_select_n;
		end
	end

	assign lk.rdata = rdata_r;
	assign lk.rdata_oe = rdata_oe_r;

	// ==================================================
	// Status flags.
	logic [fifo_pkg::FLAG_STAGES-1:0] empty_pipe_r;
	logic [fifo_pkg::FLAG_STAGES-1:0] full_pipe_r;
	logic ae_n_r;
	logic af_n_r;
	logic [15:0] af_level;

	// Almost-full threshold is depth minus the full offset.
	assign af_level = depth_now - {1'b0, full_off};

	// Empty and full each pass two register stages after the count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			empty_pipe_r <= '0;
			full_pipe_r <= '1;
		end else begin
			empty_pipe_r <= {empty_pipe_r[0], count_r != 16'h0000};
			full_pipe_r <= {full_pipe_r[0], count_r != depth_now};
		end
	end

	// Programmable flags follow the own count against the own offsets.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ae_n_r <= 1'b0;
			af_n_r <= 1'b1;
		end else begin
			ae_n_r <= count_r > {1'b0, empty_off};
			af_n_r <= count_r < af_level;
		end
	end

	assign lk.empty_indicator_n = empty_pipe_r[fifo_pkg::FLAG_STAGES-1];
	assign lk.full_indicator_n = full_pipe_r[fifo_pkg::FLAG_STAGES-1];
	assign lk.almost_empty_indicator_n = ae_n_r;
	assign lk.almost_full_indicator_n = af_n_r;
endmodule

// file: rtl/fifo_host.sv
// Writer/reader host: APB registers driving the FIFO link pins.
module fifo_host (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins toward the device
	fifo_link.host_end lk
);
	logic [fifo_pkg::CTRL_W-1:0] ctrl_r;
	logic [9:0] wdata_r;
	logic wstrobe_r;
	logic rstrobe_r;
	logic [1:0] rd_pend_r;
	logic [9:0] rcap_r;
	fifo_pkg::ser_state_e ser_r;
	logic ser_bit_r;
	logic ser_clk_r;
	logic sout_r;
	logic wr_acc;
	logic mapped;

	// ==================================================
	// APB decode: zero wait states, error on unmapped offsets.
	assign wr_acc = psel && penable && pwrite;
	assign mapped = paddr inside {fifo_pkg::REG_WDATA, fifo_pkg::REG_RDATA, fifo_pkg::REG_CTRL,
		fifo_pkg::REG_STATUS, fifo_pkg::REG_RDCMD, fifo_pkg::REG_SERIAL};
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Read mux over the host registers and the device flags.
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			fifo_pkg::REG_WDATA: prdata[9:0] = wdata_r;
			fifo_pkg::REG_RDATA: prdata[9:0] = rcap_r;
			fifo_pkg::REG_CTRL: prdata[fifo_pkg::CTRL_W-1:0] = ctrl_r;
			fifo_pkg::REG_STATUS: begin
				prdata[fifo_pkg::ST_EMPTY] = lk.empty_indicator_n;
				prdata[fifo_pkg::ST_AE] = lk.almost_empty_indicator_n;
				prdata[fifo_pkg::ST_AF] = lk.almost_full_indicator_n;
				prdata[fifo_pkg::ST_FULL] = lk.full_indicator_n;
				prdata[fifo_pkg::ST_SBUSY] = ser_r != fifo_pkg::SER_IDLE;
				prdata[fifo_pkg::ST_SOUT] = sout_r;
			end
			default: prdata = 32'h0000_0000;
		endcase
	end

	// Control straps and selects.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= fifo_pkg::CTRL_RST;
		end else if (wr_acc && paddr == fifo_pkg::REG_CTRL) begin
			ctrl_r <= pwdata[fifo_pkg::CTRL_W-1:0];
		end
	end

	// A data write issues one write gate pulse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata_r <= '0;
			wstrobe_r <= 1'b0;
		end else begin
			wstrobe_r <= wr_acc && paddr == fifo_pkg::REG_WDATA;
			if (wr_acc && paddr == fifo_pkg::REG_WDATA) begin
				wdata_r <= pwdata[9:0];
			end
		end
	end

	// A read command issues one read gate pulse; data is caught two edges later.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rstrobe_r <= 1'b0;
			rd_pend_r <= '0;
			rcap_r <= '0;
		end else begin
			rstrobe_r <= wr_acc && paddr == fifo_pkg::REG_RDCMD;
			rd_pend_r <= {rd_pend_r[0], rstrobe_r};
			if (rd_pend_r[0]) begin
				rcap_r <= lk.rdata;
			end
		end
	end

	// ==================================================
	// Serial bit sequencer: setup, clock high, clock low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_r <= fifo_pkg::SER_IDLE;
			ser_bit_r <= 1'b0;
			ser_clk_r <= 1'b0;
			sout_r <= 1'b0;
		end else begin
			unique case (ser_r)
				fifo_pkg::SER_IDLE: begin
					if (wr_acc && paddr == fifo_pkg::REG_SERIAL) begin
						ser_bit_r <= pwdata[0];
						ser_r <= fifo_pkg::SER_SETUP;
					end
				end
				fifo_pkg::SER_SETUP: begin
					sout_r <= lk.serial_out;
					ser_clk_r <= 1'b1;
					ser_r <= fifo_pkg::SER_HIGH;
				end
				fifo_pkg::SER_HIGH: begin
					ser_clk_r <= 1'b0;
					ser_r <= fifo_pkg::SER_LOW;
				end
				fifo_pkg::SER_LOW: ser_r <= fifo_pkg::SER_IDLE;
			endcase
		end
	end

	// ==================================================
	// Pin drive.
	assign lk.wdata = wdata_r;
	assign lk.write_gate_n = !wstrobe_r;
	assign lk.write_select_n = !ctrl_r[fifo_pkg::CTRL_WSEL];
	assign lk.read_gate_n = !rstrobe_r;
	assign lk.read_select_n = !ctrl_r[fifo_pkg::CTRL_RSEL];
	assign lk.fall_through_select = ctrl_r[fifo_pkg::CTRL_FT];
	assign lk.default_offset_select = ctrl_r[fifo_pkg::CTRL_DSEL +: 2];
	assign lk.quad_mode = ctrl_r[fifo_pkg::CTRL_QUAD];
	assign lk.port_width_setting = ctrl_r[fifo_pkg::CTRL_X20];
	assign lk.serial_clk = ser_clk_r;
	assign lk.serial_in = ser_bit_r;
	assign lk.serial_load_enable_n = !ctrl_r[fifo_pkg::CTRL_SLOAD];
	assign lk.serial_dump_enable_n = !ctrl_r[fifo_pkg::CTRL_SDUMP] || ctrl_r[fifo_pkg::CTRL_SLOAD];
endmodule

// file: rtl/offset_chain.sv
// Serial offset chain holding the empty and full offsets of every FIFO.
module offset_chain (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Layout and defaults
	input wire logic load_defaults,
	input wire logic [1:0] default_select,
	input wire logic quad,
	input wire logic x20,
	// Serial access
	input wire logic shift_step,
	input wire logic shift_in,
	input wire logic dump_active_n,
	input wire logic dump_step,
	output logic dump_out,
	// Offsets of the FIFO served here
	output logic [14:0] empty_offset,
	output logic [14:0] full_offset
);
	logic [fifo_pkg::CHAIN_W-1:0] chain_r;
	logic [fifo_pkg::CHAIN_W-1:0] dump_r;
	int field_w;
	int chain_len;
	int empty_idx;
	int full_idx;
	logic [14:0] mask;

	// ==================================================
	// Layout: dual x20 fields are one bit narrower and only two FIFOs exist.
	always_comb begin
		field_w = (!quad && x20) ? fifo_pkg::FIELD_W_X20 : fifo_pkg::OFF_W;
		chain_len = quad ? fifo_pkg::FIELD_N * field_w : fifo_pkg::DUAL_FIELD_N * field_w;
		empty_idx = quad ? fifo_pkg::QUAD_EMPTY0_FIELD : fifo_pkg::DUAL_EMPTY0_FIELD;
		full_idx = quad ? fifo_pkg::QUAD_FULL0_FIELD : fifo_pkg::DUAL_FULL0_FIELD;
		mask = (!quad && x20) ? fifo_pkg::OFF_MASK_X20 : fifo_pkg::OFF_MASK_X10;
	end

	// Fields are read at their chain position; the first serial bit is the LSB.
	assign empty_offset = 15'(chain_r >> (empty_idx * field_w)) & mask;
	assign full_offset = 15'(chain_r >> (full_idx * field_w)) & mask;

	// ==================================================
	// New bits enter at the chain end so the first bit lands at position zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain_r <= '0;
		end else if (load_defaults) begin
			chain_r <= '0;
			for (int f = 0; f < fifo_pkg::FIELD_N; f++) begin
				if (quad || f < fifo_pkg::DUAL_FIELD_N) begin
					chain_r[f * field_w +: 15] <= fifo_pkg::default_offset(default_select) & mask;
				end
			end
		end else if (shift_step) begin
			for (int i = 0; i < fifo_pkg::CHAIN_W; i++) begin
				if (i == chain_len - 1) begin
					chain_r[i] <= shift_in;
				end else if (i < chain_len - 1) begin
					chain_r[i] <= chain_r[i + 1];
				end else begin
					chain_r[i] <= 1'b0;
				end
			end
		end
	end

	// Dump copy is taken while idle, then shifted out with zero fill.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dump_r <= '0;
		end else if (dump_active_n) begin
			dump_r <= chain_r;
		end else if (dump_step) begin
			dump_r <= {1'b0, dump_r[fifo_pkg::CHAIN_W-1:1]};
		end
	end

	assign dump_out = dump_r[0];
endmodule

// file: shared/fifo_link.sv
// Pin-level link between the FIFO device and its writer/reader host.
interface fifo_link;
	logic [9:0] wdata;
	logic write_gate_n;
	logic write_select_n;
	logic [9:0] rdata;
	logic rdata_oe;
	logic read_gate_n;
	logic read_select_n;
	logic empty_indicator_n;
	logic almost_empty_indicator_n;
	logic almost_full_indicator_n;
	logic full_indicator_n;
	logic fall_through_select;
	logic [1:0] default_offset_select;
	logic quad_mode;
	logic port_width_setting;
	logic serial_clk;
	logic serial_in;
	logic serial_load_enable_n;
	logic serial_dump_enable_n;
	logic serial_out;

	modport device_end (
		input wdata, write_gate_n, write_select_n, read_gate_n, read_select_n,
		input fall_through_select, default_offset_select, quad_mode, port_width_setting,
		input serial_clk, serial_in, serial_load_enable_n, serial_dump_enable_n,
		output rdata, rdata_oe, empty_indicator_n, almost_empty_indicator_n,
		output almost_full_indicator_n, full_indicator_n, serial_out
	);

	modport host_end (
		output wdata, write_gate_n, write_select_n, read_gate_n, read_select_n,
		output fall_through_select, default_offset_select, quad_mode, port_width_setting,
		output serial_clk, serial_in, serial_load_enable_n, serial_dump_enable_n,
		input rdata, rdata_oe, empty_indicator_n, almost_empty_indicator_n,
		input almost_full_indicator_n, full_indicator_n, serial_out
	);
endinterface

// file: shared/fifo_pkg.sv
// Shared constants, register map and helpers for the FIFO flag link.
package fifo_pkg;

	// ==================================================
	// Data path and depth
	localparam int DATA_W = 10;
	localparam int CNT_W = 16;
	localparam int PTR_W = 15;
	localparam logic [15:0] DEPTH_X10 = 16'h8000;
	localparam logic [15:0] DEPTH_X20 = 16'h4000;
	localparam int FLAG_STAGES = 2;

	// ==================================================
	// Offset chain layout
	localparam int OFF_W = 15;
	localparam int FIELD_W_X20 = 14;
	localparam int FIELD_N = 8;
	localparam int DUAL_FIELD_N = 4;
	localparam int CHAIN_W = 120;
	localparam int QUAD_EMPTY0_FIELD = 6;
	localparam int QUAD_FULL0_FIELD = 7;
	localparam int DUAL_EMPTY0_FIELD = 2;
	localparam int DUAL_FULL0_FIELD = 3;
	localparam logic [14:0] OFF_MASK_X10 = 15'h7fff;
	localparam logic [14:0] OFF_MASK_X20 = 15'h3fff;
	localparam logic [14:0] DEF_OFF_SEL0 = 15'h0007;
	localparam logic [14:0] DEF_OFF_SEL1 = 15'h003f;
	localparam logic [14:0] DEF_OFF_SEL2 = 15'h007f;
	localparam logic [14:0] DEF_OFF_SEL3 = 15'h03ff;

	// ==================================================
	// Host register map and fields
	localparam logic [7:0] REG_WDATA = 8'h00;
	localparam logic [7:0] REG_RDATA = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDCMD = 8'h10;
	localparam logic [7:0] REG_SERIAL = 8'h14;
	localparam int CTRL_WSEL = 0;
	localparam int CTRL_RSEL = 1;
	localparam int CTRL_FT = 2;
	localparam int CTRL_DSEL = 3;
	localparam int CTRL_QUAD = 5;
	localparam int CTRL_X20 = 6;
	localparam int CTRL_SLOAD = 7;
	localparam int CTRL_SDUMP = 8;
	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RST = 9'h020;
	localparam int ST_EMPTY = 0;
	localparam int ST_AE = 1;
	localparam int ST_AF = 2;
	localparam int ST_FULL = 3;
	localparam int ST_SBUSY = 4;
	localparam int ST_SOUT = 5;

	typedef enum logic [1:0] {SER_IDLE, SER_SETUP, SER_HIGH, SER_LOW} ser_state_e;

	// Default offset chosen by the two select straps.
	function automatic logic [14:0] default_offset(input logic [1:0] sel);
		unique case (sel)
			2'h0: default_offset = DEF_OFF_SEL0;
			2'h1: default_offset = DEF_OFF_SEL1;
			2'h2: default_offset = DEF_OFF_SEL2;
			2'h3: default_offset = DEF_OFF_SEL3;
		endcase
	endfunction

endpackage

// file: tb/fifo_standard_mode_flags_checker.sv
// Concurrent checks on the FIFO link between host and device.
module fifo_standard_mode_flags_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Writer and reader controls
	input wire logic write_gate_n,
	input wire logic write_select_n,
	input wire logic read_gate_n,
	input wire logic read_select_n,
	// Straps and serial load
	input wire logic fall_through_select,
	input wire logic [1:0] default_offset_select,
	input wire logic quad_mode,
	input wire logic port_width_setting,
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic serial_load_enable_n,
	// Device outputs
	input wire logic [9:0] rdata,
	input wire logic rdata_oe,
	input wire logic empty_indicator_n,
	input wire logic almost_empty_indicator_n,
	input wire logic almost_full_indicator_n,
	input wire logic full_indicator_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====================
	// Reference count and offsets
	logic cfg_r, quad_r, x20_r, std_r, sck_r, wr, rd;
	logic [15:0] cnt_r, depth, af_lim;
	logic [119:0] chain_r;
	logic [14:0] dflt, n_off, m_off;
	// Strap default, depth, offsets and accepted operations.
	assign dflt = default_offset_select[1] ?
		(default_offset_select[0] ? fifo_pkg::DEF_OFF_SEL3 : fifo_pkg::DEF_OFF_SEL2) :
		(default_offset_select[0] ? fifo_pkg::DEF_OFF_SEL1 : fifo_pkg::DEF_OFF_SEL0);
	assign depth = (!quad_r && x20_r) ? fifo_pkg::DEPTH_X20 : fifo_pkg::DEPTH_X10;
	assign n_off = quad_r ? chain_r[104:90] : chain_r[14:0];
	assign m_off = quad_r ? chain_r[119:105] : chain_r[29:15];
	assign af_lim = depth - {1'b0, m_off};
	assign wr = cfg_r && std_r && !write_gate_n && !write_select_n && cnt_r != depth;
	assign rd = cfg_r && std_r && !read_gate_n && !read_select_n && cnt_r != 16'h0000;
	// Straps are caught once; the chain then shifts on each rising serial clock while load enable is low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= 1'b0;
			quad_r <= 1'b1;
			x20_r <= 1'b0;
			std_r <= 1'b0;
			chain_r <= '0;
		end else if (!cfg_r) begin
			cfg_r <= 1'b1;
			quad_r <= quad_mode;
			x20_r <= port_width_setting;
			std_r <= !fall_through_select;
			chain_r <= {8{dflt}};
		end else if (serial_clk && !sck_r && !serial_load_enable_n) begin
			chain_r <= {serial_in, chain_r[119:1]};
		end
	end
	// Stored word count follows accepted writes and reads.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			sck_r <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 16'(wr) - 16'(rd);
			sck_r <= serial_clk;
		end
	end
	// ====================
	// Assertions
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_first_write;
		wr && !rd && cnt_r == 16'h0000;
	endsequence
	sequence s_empty_rise;
		##2 !empty_indicator_n ##1 empty_indicator_n;
	endsequence
	sequence s_read_at_full;
		rd && cnt_r == depth;
	endsequence
	sequence s_full_release;
		##2 !full_indicator_n ##1 full_indicator_n;
	endsequence
	property p_empty_lag;
		empty_indicator_n == ($past(cnt_r, 2) != 16'h0000);
	endproperty
	property p_full_lag;
		full_indicator_n == ($past(cnt_r, 2) != $past(depth, 2));
	endproperty
	property p_ae_level;
		almost_empty_indicator_n == ($past(cnt_r) > {1'b0, $past(n_off)});
	endproperty
	property p_af_level;
		almost_full_indicator_n == ($past(cnt_r) < $past(af_lim));
	endproperty
	property p_first_write;
		s_first_write |-> s_empty_rise;
	endproperty
	property p_full_release;
		s_read_at_full |-> s_full_release;
	endproperty
	property p_ae_rise;
		wr && !rd && cnt_r == {1'b0, n_off} |-> ##1 !almost_empty_indicator_n
			##1 almost_empty_indicator_n;
	endproperty
	property p_oe_follows;
		cfg_r |-> rdata_oe == !$past(read_select_n);
	endproperty
	property p_rdata_hold;
		cfg_r && !rd |=> $stable(rdata);
	endproperty
	a_empty_lag: assert property (p_empty_lag)
		else $error("empty flag does not follow the count");
	a_full_lag: assert property (p_full_lag)
		else $error("full flag does not follow the count");
	a_ae_level: assert property (p_ae_level)
		else $error("almost empty flag wrong for count");
	a_af_level: assert property (p_af_level)
		else $error("almost full flag wrong for count");
	a_first_write: assert property (p_first_write)
		else $error("empty flag did not rise after first write");
	a_full_release: assert property (p_full_release)
		else $error("full flag not released by first read");
	a_ae_rise: assert property (p_ae_rise)
		else $error("almost empty flag did not rise at offset plus one");
	a_oe_follows: assert property (p_oe_follows)
		else $error("output enable does not follow read select");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without an accepted read");
endmodule

// file: tb/fifo_standard_mode_flags_tb_top.sv
// Top-level bench joining host and device across the FIFO link.
module fifo_standard_mode_flags_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ====================
	// Signals and instances
	logic pclk, presetn, dev_rstn, psel, penable, pwrite, pready, pslverr, standard_mode, re;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rq;
	logic [15:0] fill_level;
	int mismatches, checked, wn, rn;
	fifo_link fifo_link_i();
	fifo_host fifo_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lk(fifo_link_i));
	fifo_device fifo_device_i (.pclk(pclk), .presetn(dev_rstn), .lk(fifo_link_i),
		.standard_mode(standard_mode), .fill_level(fill_level));
	fifo_standard_mode_flags_checker fifo_standard_mode_flags_checker_i (.pclk(pclk),
		.presetn(dev_rstn), .write_gate_n(fifo_link_i.write_gate_n),
		.write_select_n(fifo_link_i.write_select_n), .read_gate_n(fifo_link_i.read_gate_n),
		.read_select_n(fifo_link_i.read_select_n),
		.fall_through_select(fifo_link_i.fall_through_select),
		.default_offset_select(fifo_link_i.default_offset_select),
		.quad_mode(fifo_link_i.quad_mode), .port_width_setting(fifo_link_i.port_width_setting),
		.serial_clk(fifo_link_i.serial_clk), .serial_in(fifo_link_i.serial_in),
		.serial_load_enable_n(fifo_link_i.serial_load_enable_n), .rdata(fifo_link_i.rdata),
		.rdata_oe(fifo_link_i.rdata_oe), .empty_indicator_n(fifo_link_i.empty_indicator_n),
		.almost_empty_indicator_n(fifo_link_i.almost_empty_indicator_n),
		.almost_full_indicator_n(fifo_link_i.almost_full_indicator_n),
		.full_indicator_n(fifo_link_i.full_indicator_n));
	// ====================
	// Tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer after an idle cycle; data and error are taken at the access edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Flags settle within four cycles of the last write.
	task automatic stat(input logic [3:0] e);
		repeat (4) @(posedge pclk);
		apb(1'b0, fifo_pkg::REG_STATUS, 32'h0);
		chk("status", {28'h0, rq[3:0]}, {28'h0, e});
	endtask
	task automatic push(input int k);
		repeat (k) begin
			apb(1'b1, fifo_pkg::REG_WDATA, {22'h0, wn[9:0]});
			wn++;
		end
	endtask
	// Each read is requested, then the captured word is compared in order.
	task automatic pop(input int k);
		repeat (k) begin
			apb(1'b1, fifo_pkg::REG_RDCMD, 32'h0);
			repeat (3) @(posedge pclk);
			apb(1'b0, fifo_pkg::REG_RDATA, 32'h0);
			chk("rdata", rq, {22'h0, rn[9:0]});
			rn++;
		end
	endtask
	// Straps are set first, since the device catches them on leaving reset.
	task automatic devrst(input logic [31:0] ctrl);
		apb(1'b1, fifo_pkg::REG_CTRL, ctrl);
		@(posedge pclk);
		dev_rstn <= 1'b0;
		repeat (2) @(posedge pclk);
		dev_rstn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	task automatic conclude();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ====================
	// Clock, watchdog and tests
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#(90000 * 10);
		mismatches++;
		conclude();
	end
	initial begin
		presetn = 1'b0;
		dev_rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		checked = 0;
		wn = 1;
		rn = 1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		dev_rstn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("mode", {31'h0, standard_mode}, 32'h1);
		stat(4'hc);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped error", {31'h0, re}, 32'h1);
		chk("unmapped data", rq, 32'h0);
		apb(1'b1, fifo_pkg::REG_WDATA, 32'h3ff);
		stat(4'hc);
		chk("level", {16'h0, fill_level}, 32'h0);
		apb(1'b1, fifo_pkg::REG_CTRL, 32'h023);
		apb(1'b1, fifo_pkg::REG_RDCMD, 32'h0);
		repeat (3) @(posedge pclk);
		chk("oe", {31'h0, fifo_link_i.rdata_oe}, 32'h1);
		chk("level", {16'h0, fill_level}, 32'h0);
		push(1);
		stat(4'hd);
		push(6);
		stat(4'hd);
		push(1);
		stat(4'hf);
		apb(1'b0, fifo_pkg::REG_RDATA, 32'h0);
		chk("rdata before request", rq, 32'h0);
		pop(1);
		stat(4'hd);
		pop(7);
		stat(4'hc);
		apb(1'b1, fifo_pkg::REG_RDCMD, 32'h0);
		repeat (3) @(posedge pclk);
		apb(1'b0, fifo_pkg::REG_RDATA, 32'h0);
		chk("rdata when empty", rq, 32'h8);
		apb(1'b1, fifo_pkg::REG_CTRL, 32'h021);
		repeat (2) @(posedge pclk);
		chk("oe", {31'h0, fifo_link_i.rdata_oe}, 32'h0);
		// Chain load: empty offset 0 becomes 3, every other field all ones.
		apb(1'b1, fifo_pkg::REG_CTRL, 32'h0a3);
		for (int k = 0; k < 120; k++) begin
			apb(1'b1, fifo_pkg::REG_SERIAL, (k > 91 && k < 105) ? 32'h0 : 32'h1);
			for (int t = 0; t < 8; t++) begin
				apb(1'b0, fifo_pkg::REG_STATUS, 32'h0);
				if (rq[4] === 1'b0) break;
			end
		end
		apb(1'b1, fifo_pkg::REG_CTRL, 32'h023);
		push(3);
		stat(4'h9);
		push(1);
		stat(4'hb);
		pop(4);
		stat(4'hc);
		// Dump: the bit caught before the 93rd pulse is bit 2 of empty offset 0.
		apb(1'b1, fifo_pkg::REG_CTRL, 32'h123);
		for (int k = 0; k < 93; k++) begin
			apb(1'b1, fifo_pkg::REG_SERIAL, 32'h0);
			stat(4'hc);
		end
		chk("dump bit", {31'h0, rq[5]}, 32'h0);
		// Dual x20 layout with both offsets at 1023.
		devrst(32'h05b);
		push(15360);
		stat(4'hf);
		push(1);
		stat(4'hb);
		push(1022);
		stat(4'hb);
		push(1);
		stat(4'h3);
		apb(1'b1, fifo_pkg::REG_WDATA, 32'h155);
		repeat (3) @(posedge pclk);
		chk("level", {16'h0, fill_level}, 32'h4000);
		pop(1);
		stat(4'hb);
		pop(1022);
		stat(4'hb);
		pop(1);
		stat(4'hf);
		devrst(32'h027);
		chk("mode", {31'h0, standard_mode}, 32'h0);
		apb(1'b1, fifo_pkg::REG_WDATA, 32'h1);
		repeat (3) @(posedge pclk);
		chk("level", {16'h0, fill_level}, 32'h0);
		conclude();
	end
endmodule
